/* File: cpie_defs.vh */
// register map, field positions and reset values of the protection interrupt block
`ifndef CPIE_DEFS_VH
`define CPIE_DEFS_VH

// bus widths
`define CPIE_AW 8
`define CPIE_DW 8

// register offsets
`define CPIE_ADDR_CFG 8'hc2
`define CPIE_ADDR_IEN 8'hc6
`define CPIE_ADDR_STS 8'hc7

// reset values
`define CPIE_IEN_RST 8'h00
`define CPIE_STS_RST 8'h00
`define CPIE_CFG_RST 8'h00
`define CPIE_ZERO 8'h00

// enable and status bit positions (same layout)
`define CPIE_B_IND 7
`define CPIE_B_RXDET 6
`define CPIE_B_DSIRQ 5
`define CPIE_B_LIST 4
`define CPIE_B_KEY 3
`define CPIE_B_FAIL 2
`define CPIE_B_PASS 1
`define CPIE_B_GLOB 0

// source bits range
`define CPIE_SRC_HI 7
`define CPIE_SRC_LO 1

// config bit: receiver detect waits for lock
`define CPIE_B_WAITLOCK 0

// level of the downstream interrupt pin that means asserted
`define CPIE_DSIRQ_ACTIVE 1'b0

`endif

/* File: cpie_irq_ctrl.v */
// interrupt enable, sticky status and gating for the content protection transmitter
// Notes on behaviour
// [R1] bit 7 enables the indirect register access complete source
// [R2] bit 6 enables the downstream receiver detect source
// [R3] with wait-lock select set, receiver detect waits for downstream lock
// [R4] bit 5 enables forwarding of the downstream receiver interrupt
// [R5] bit 4 enables the key list ready source
// [R6] bit 3 enables the receiver key ready source
// [R7] bit 2 enables failure or later loss of authentication
// [R8] interrupt output only while global enable bit 0 is set
// [R9] bit 1 enables the authentication pass source
// [R10] global status flag set while any enabled source is indicated
// [R11] downstream interrupt pin is active low; zero means asserted
//
// Our own choice: strobed register access.

`include "cpie_defs.vh"

module cpie_irq_ctrl (
	input wire clk_in,
	input wire rstn_in,
	input wire [`CPIE_AW-1:0] addr_in,
	input wire [`CPIE_DW-1:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	input wire ind_access_done_in,
	input wire receiver_detect_in,
	input wire receiver_lock_in,
	input wire downstream_irq_input_in,
	input wire key_list_ready_in,
	input wire receiver_key_ready_in,
	input wire authed_in,
	input wire auth_fail_in,
	output wire [`CPIE_DW-1:0] rdata_out,
	output wire irq_out
);

	// address match, shared by the write and read decode
	function hit;
		input [`CPIE_AW-1:0] a;
		input [`CPIE_AW-1:0] b;
		begin
			hit = (a == b);
		end
	endfunction

	reg [`CPIE_DW-1:0] ien_r;
	reg [`CPIE_DW-1:0] cfg_r;
	reg [`CPIE_DW-1:0] sts_r;
	wire [`CPIE_DW-1:0] sts_nxt;
	reg [`CPIE_DW-1:0] rdata_r;
	reg [`CPIE_DW-1:0] rdata_nxt;
	reg irq_r;
	reg irq_nxt;
	wire glob_nxt;

	// downstream pin synchroniser
	reg ds_meta_r;
	reg ds_sync_r;

	// previous values for edge detection
	reg rxdet_prev_r;
	reg list_prev_r;
	reg key_prev_r;
	reg authed_prev_r;
	reg ind_prev_r;

	wire wr_ien;
	wire wr_cfg;
	wire wr_sts;
	wire rxdet_cond;
	wire ds_active;
	wire [`CPIE_DW-1:0] ev;
	wire [`CPIE_DW-1:0] clr;

	assign wr_ien = wr_in & hit(addr_in, `CPIE_ADDR_IEN);
	assign wr_cfg = wr_in & hit(addr_in, `CPIE_ADDR_CFG);
	assign wr_sts = wr_in & hit(addr_in, `CPIE_ADDR_STS);

	// the pin comes from the far side of the link, so two flops first
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ds_meta_r <= 1'b1;
			ds_sync_r <= 1'b1;
		end else begin
			ds_meta_r <= downstream_irq_input_in;
			ds_sync_r <= ds_meta_r;
		end
	end

	// low level on the pin is an asserted request
	assign ds_active = (ds_sync_r == `CPIE_DSIRQ_ACTIVE); // [R11]

	// detect may be held back until the receiver also reports lock
	assign rxdet_cond = receiver_detect_in &
		(receiver_lock_in | ~cfg_r[`CPIE_B_WAITLOCK]); // [R3]

	// edge history of level sources
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rxdet_prev_r <= 1'b0;
			list_prev_r <= 1'b0;
			key_prev_r <= 1'b0;
			authed_prev_r <= 1'b0;
			ind_prev_r <= 1'b0;
		end else begin
			rxdet_prev_r <= rxdet_cond;
			list_prev_r <= key_list_ready_in;
			key_prev_r <= receiver_key_ready_in;
			authed_prev_r <= authed_in;
			ind_prev_r <= ind_access_done_in;
		end
	end

	// source events, one per status bit; one-cycle edges except the downstream level and the failure input
	assign ev[`CPIE_B_IND] = ind_access_done_in & ~ind_prev_r; // [R1]
	assign ev[`CPIE_B_RXDET] = rxdet_cond & ~rxdet_prev_r; // [R2]
	// level source: a held request keeps re-setting its bit
	assign ev[`CPIE_B_DSIRQ] = ds_active; // [R4]
	assign ev[`CPIE_B_LIST] = key_list_ready_in & ~list_prev_r; // [R5]
	assign ev[`CPIE_B_KEY] = receiver_key_ready_in & ~key_prev_r; // [R6]
	// a failure pulse or a drop of the authenticated state
	assign ev[`CPIE_B_FAIL] = auth_fail_in | (authed_prev_r & ~authed_in); // [R7]
	assign ev[`CPIE_B_PASS] = authed_in & ~authed_prev_r; // [R9]
	assign ev[`CPIE_B_GLOB] = 1'b0;

	// write one to clear, source bits only
	assign clr = wr_sts ? wdata_in : `CPIE_ZERO;

	// sticky status bits; a set in the clearing cycle wins
	// continuous assigns per bit keep one driver for each bit of the vector
	genvar gi;
	generate
		for (gi = `CPIE_SRC_LO; gi <= `CPIE_SRC_HI; gi = gi + 1) begin : g_sts
			assign sts_nxt[gi] = ev[gi] | (sts_r[gi] & ~clr[gi]);
		end
	endgenerate

	// global flag follows the enabled sources
	assign glob_nxt = |(sts_nxt[`CPIE_SRC_HI:`CPIE_SRC_LO] &
		ien_r[`CPIE_SRC_HI:`CPIE_SRC_LO]); // [R10]
	assign sts_nxt[`CPIE_B_GLOB] = glob_nxt;

	// output gated by the global enable, taken from the flopped status
	always @* begin
		irq_nxt = ien_r[`CPIE_B_GLOB] & sts_r[`CPIE_B_GLOB]; // [R8]
	end

	// status and interrupt registers
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sts_r <= `CPIE_STS_RST;
			irq_r <= 1'b0;
		end else begin
			sts_r <= sts_nxt;
			irq_r <= irq_nxt;
		end
	end

	// software enable and config registers
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ien_r <= `CPIE_IEN_RST;
			cfg_r <= `CPIE_CFG_RST;
		end else begin
			if (wr_ien) begin
				ien_r <= wdata_in; // [R1] [R2] [R4] [R5] [R6] [R7] [R8] [R9]
			end
			if (wr_cfg) begin
				cfg_r[`CPIE_B_WAITLOCK] <= wdata_in[`CPIE_B_WAITLOCK];
			end
		end
	end

	// read mux; data stands only in the cycle after the strobe
	always @* begin
		rdata_nxt = `CPIE_ZERO;
		if (rd_in) begin
			if (hit(addr_in, `CPIE_ADDR_IEN)) begin
				rdata_nxt = ien_r;
			end else if (hit(addr_in, `CPIE_ADDR_STS)) begin
				rdata_nxt = sts_r;
			end else if (hit(addr_in, `CPIE_ADDR_CFG)) begin
				rdata_nxt = cfg_r;
			end else begin
				rdata_nxt = `CPIE_ZERO; // unmapped reads as zero
			end
		end
	end

	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_r <= `CPIE_ZERO;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_out = rdata_r;
	assign irq_out = irq_r;

endmodule

/* File: cpie_irq_monitor.sv */
// checker of source gating for the protection interrupt block
`include "cpie_defs.vh"
module cpie_irq_monitor (
	input wire clk_in,
	input wire rstn_in,
	input wire [7:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire ind_access_done_in,
	input wire receiver_detect_in,
	input wire downstream_irq_input_in,
	input wire key_list_ready_in,
	input wire receiver_key_ready_in,
	input wire authed_in,
	input wire auth_fail_in,
	input wire irq_out
);
	logic [7:0] ien_r;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// shadow of the enables; assumes they hold while a request is in flight
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) ien_r <= 8'h00;
		else if (wr_in && addr_in == `CPIE_ADDR_IEN) ien_r <= wdata_in;
	end
	function automatic logic on(int b);
		return ien_r[0] & ien_r[b];
	endfunction
	a_ind_src: assert property ($rose(ind_access_done_in) && on(7) |-> ##2 irq_out)
		else $error("missed irq");
	a_det_src: assert property ($rose(receiver_detect_in) && on(6) |-> ##2 irq_out)
		else $error("missed irq");
	a_ds_src: assert property ($fell(downstream_irq_input_in) && on(5) |-> ##[2:5] irq_out)
		else $error("missed irq");
	a_list_src: assert property ($rose(key_list_ready_in) && on(4) |-> ##2 irq_out)
		else $error("missed irq");
	a_key_src: assert property ($rose(receiver_key_ready_in) && on(3) |-> ##2 irq_out)
		else $error("missed irq");
	a_fail_src: assert property (($fell(authed_in) || auth_fail_in) && on(2) |-> ##2 irq_out)
		else $error("missed irq");
	a_pass_src: assert property ($rose(authed_in) && on(1) |-> ##2 irq_out)
		else $error("missed irq");
	a_glob_gate: assert property (!ien_r[0] |=> !irq_out)
		else $error("irq while off");
endmodule
bind cpie_irq_ctrl cpie_irq_monitor i_cpie_irq_monitor (.clk_in, .rstn_in, .addr_in, .wdata_in,
	.wr_in, .ind_access_done_in, .receiver_detect_in, .downstream_irq_input_in,
	.key_list_ready_in, .receiver_key_ready_in, .authed_in, .auth_fail_in, .irq_out);

/* File: cpie_host.sv */
// host model: counts new requests on the level interrupt line
module cpie_host (
	input wire clk_in,
	input wire irq_in,
	output int rises_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_r = 1'h0;
	initial rises_out = 0;
	// a handler only reacts to a new request, the level itself is left alone
	always @(posedge clk_in) begin
		if (irq_in && !last_r) rises_out <= rises_out + 1;
		last_r <= irq_in;
	end
endmodule

/* File: tb.sv */
// self-checking bench for the protection interrupt block
`include "cpie_defs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = '0, rstn_in = '0, wr_in = '0, rd_in = '0, rd_d = '0, receiver_lock_in = '0;
	logic [7:0] addr_in = '0, wdata_in = '0, src = '0, rdata_out, v, q[$];
	logic irq_out;
	int error_cnt = 0, samples_checked = 0, seed = 32'h1e83, host_rises;
	always #20 clk_in = ~clk_in;
	cpie_irq_ctrl i_cpie_irq_ctrl (.clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.ind_access_done_in(src[7]), .receiver_detect_in(src[6]), .receiver_lock_in,
		.downstream_irq_input_in(!src[5]), .key_list_ready_in(src[4]),
		.receiver_key_ready_in(src[3]), .auth_fail_in(src[2]), .authed_in(src[1]),
		.rdata_out, .irq_out);
	cpie_host i_cpie_host (.clk_in, .irq_in(irq_out), .rises_out(host_rises));
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// one bus cycle; a read leaves its expected data in the queue
	task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
		@(posedge clk_in);
		if (!w) q.push_back(d);
		{wr_in, rd_in, addr_in, wdata_in} <= {w, !w, a, d};
		@(posedge clk_in);
		{wr_in, rd_in} <= 2'h0;
	endtask
	// read data stand only in the cycle after the strobe
	always @(posedge clk_in) begin
		if (rd_d) chk("rdata", rdata_out, q.pop_front());
		rd_d <= rd_in;
	end
	// a stale bit left by a failed clear shows up in the next source's read
	task automatic ev(int b);
		src[b] <= 1'h1;
		repeat (5) @(posedge clk_in);
		if (b != 1) src[b] <= 1'h0;
		bus(0, `CPIE_ADDR_STS, 8'h01 | (8'h01 << b));
		#1 chk("irq", {7'h0, irq_out}, 8'h01);
		bus(1, `CPIE_ADDR_STS, 8'h01 << b);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_in);
		rstn_in <= 1'h1;
		bus(0, `CPIE_ADDR_IEN, `CPIE_IEN_RST);
		bus(0, `CPIE_ADDR_STS, `CPIE_STS_RST);
		bus(0, 8'h10, `CPIE_ZERO);
		v = $random(seed);
		bus(1, `CPIE_ADDR_IEN, v);
		bus(0, `CPIE_ADDR_IEN, v);
		bus(1, `CPIE_ADDR_IEN, 8'hff);
		for (int b = 7; b > 0; b--) ev(b);
		src[1] <= 1'h0;
		repeat (3) @(posedge clk_in);
		bus(0, `CPIE_ADDR_STS, 8'h05);
		bus(1, `CPIE_ADDR_IEN, 8'hfe);
		repeat (2) @(posedge clk_in);
		#1 chk("irq", {7'h0, irq_out}, 8'h00);
		bus(1, `CPIE_ADDR_IEN, 8'hbf);
		@(posedge clk_in);
		#1 chk("irq", {7'h0, irq_out}, 8'h01);
		bus(1, `CPIE_ADDR_STS, 8'h04);
		bus(1, `CPIE_ADDR_CFG, 8'h01);
		src[6] <= 1'h1;
		repeat (4) @(posedge clk_in);
		bus(0, `CPIE_ADDR_STS, 8'h00);
		receiver_lock_in <= 1'h1;
		repeat (3) @(posedge clk_in);
		bus(0, `CPIE_ADDR_STS, 8'h40);
		repeat (2) @(posedge clk_in);
		// seven sources, the later loss of authentication and the re-enable
		chk("host rises", host_rises[7:0], 8'h09);
		complete_run;
	end
endmodule
